// ### design/diag_digital_input_unit.sv
// eight-channel digital input unit with filter, edge and fault interrupts
// assumes field inputs and fault comparators are asynchronous to clk
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module diag_digital_input_unit #(
  parameter int unsigned delay0_cycles = diag_input_pkg::delay0_cyc,
  parameter int unsigned delay1_cycles = diag_input_pkg::delay1_cyc,
  parameter int unsigned delay2_cycles = diag_input_pkg::delay2_cyc,
  parameter int unsigned delay3_cycles = diag_input_pkg::delay3_cyc
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  field_in,
  input  wire logic [7:0]  short_det,
  input  wire logic [7:0]  break_det,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic      [7:0]  level,
  output logic      [7:0]  channel_fault,
  output logic             group_fault_indicator,
  output logic             irq
);
  localparam int cw = 24;

  logic [7:0] in_m, in_s, sh_m, sh_s, br_m, br_s;
  logic [1:0] delay_sel;
  logic       diag_irq_en, hw_irq_en;
  diag_input_pkg::diag_en_s diag_en;
  diag_input_pkg::edge_en_s edge_en;
  diag_input_pkg::event_s   status, irq_en, ev;
  logic [cw-1:0] limit;
  logic [7:0] rise_ev, fall_ev;
  logic [7:0] flt_short, flt_break;

  // field pins are asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_m <= 8'h00;
      in_s <= 8'h00;
      sh_m <= 8'h00;
      sh_s <= 8'h00;
      br_m <= 8'h00;
      br_s <= 8'h00;
    end else begin
      in_m <= field_in;
      in_s <= in_m;
      sh_m <= short_det;
      sh_s <= sh_m;
      br_m <= break_det;
      br_s <= br_m;
    end
  end

  always_comb begin
    unique case (delay_sel)
      2'h0: limit = cw'(delay0_cycles);
      2'h1: limit = cw'(delay1_cycles);
      2'h2: limit = cw'(delay2_cycles);
      2'h3: limit = cw'(delay3_cycles);
    endcase
  end

  // per-channel filter: level must hold a full delay before it is accepted
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      logic [cw-1:0] cnt;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt      <= '0;
          level[g] <= 1'b0;
        end else if (in_s[g] == level[g]) begin
          cnt <= '0;
        end else if (cnt + cw'(1) >= limit) begin
          cnt      <= '0;
          level[g] <= in_s[g];
        end else begin
          cnt <= cnt + cw'(1);
        end
      end
      assign rise_ev[g] = in_s[g] & ~level[g] & (cnt + cw'(1) >= limit);
      assign fall_ev[g] = ~in_s[g] & level[g] & (cnt + cw'(1) >= limit);
    end
  endgenerate

  assign flt_short = sh_s & diag_en.short_en;
  assign flt_break = br_s & diag_en.break_en;
  assign channel_fault = flt_short | flt_break;
  assign group_fault_indicator = |channel_fault;

  logic [7:0] flt_short_q, flt_break_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flt_short_q <= 8'h00;
      flt_break_q <= 8'h00;
    end else begin
      flt_short_q <= flt_short;
      flt_break_q <= flt_break;
    end
  end

  // events: fault onsets need the module diagnostic enable
  always_comb begin
    ev.rise       = rise_ev & edge_en.rise_en & {8{hw_irq_en}};
    ev.fall       = fall_ev & edge_en.fall_en & {8{hw_irq_en}};
    ev.short_gnd  = flt_short & ~flt_short_q & {8{diag_irq_en}};
    ev.wire_break = flt_break & ~flt_break_q & {8{diag_irq_en}};
  end

  logic wr_cfg, wr_diag, wr_edge, wr_clr, wr_ien;
  assign wr_cfg  = wr && addr == diag_input_pkg::off_config;
  assign wr_diag = wr && addr == diag_input_pkg::off_diag_en;
  assign wr_edge = wr && addr == diag_input_pkg::off_edge_en;
  assign wr_clr  = wr && addr == diag_input_pkg::off_clear;
  assign wr_ien  = wr && addr == diag_input_pkg::off_irq_en;

  logic next_hw_en;
  assign next_hw_en = wr_cfg ? wdata[diag_input_pkg::cfg_hw_irq] : hw_irq_en;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      delay_sel   <= diag_input_pkg::delay_sel_rst;
      diag_irq_en <= 1'b0;
      hw_irq_en   <= 1'b0;
    end else if (wr_cfg) begin
      delay_sel   <= wdata[diag_input_pkg::cfg_delay_lsb +: 2];
      diag_irq_en <= wdata[diag_input_pkg::cfg_diag_irq];
      hw_irq_en   <= wdata[diag_input_pkg::cfg_hw_irq];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      diag_en <= '0;
    end else if (wr_diag) begin
      diag_en <= wdata[15:0];
    end
  end

  // edge enables only hold while the hardware interrupt is enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_en <= '0;
    end else if (!next_hw_en) begin
      edge_en <= '0;
    end else if (wr_edge) begin
      edge_en <= wdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en <= '0;
    end else if (wr_ien) begin
      irq_en <= wdata;
    end
  end

  // set wins over a simultaneous clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      status <= (status & ~(wr_clr ? wdata : 32'h0000_0000)) | ev;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_en);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        diag_input_pkg::off_input:   rdata <= {24'h00_0000, level};
        diag_input_pkg::off_config:  rdata <= {28'h000_0000, hw_irq_en, diag_irq_en, delay_sel};
        diag_input_pkg::off_diag_en: rdata <= {16'h0000, diag_en};
        diag_input_pkg::off_edge_en: rdata <= {16'h0000, edge_en};
        diag_input_pkg::off_fault:   rdata <= {16'h0000, flt_break, flt_short};
        diag_input_pkg::off_status:  rdata <= status;
        diag_input_pkg::off_irq_en:  rdata <= irq_en;
        default:                     rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // helper for the filter checks: disagreeing cycles in a row on channel 0
  logic [cw-1:0] run0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run0 <= '0;
    end else if (in_s[0] == level[0]) begin
      run0 <= '0;
    end else if (run0 != '1) begin
      run0 <= run0 + cw'(1);
    end
  end

  // interrupt path: event, sticky bit a cycle later, irq one more
  sequence s_rise_event;
    (ev.rise & irq_en.rise) != 8'h00 && !wr_ien;
  endsequence
  sequence s_rise_raised;
    (status.rise & irq_en.rise) != 8'h00 ##1 irq;
  endsequence
  sequence s_fall_event;
    (ev.fall & irq_en.fall) != 8'h00 && !wr_ien;
  endsequence
  sequence s_fall_raised;
    (status.fall & irq_en.fall) != 8'h00 ##1 irq;
  endsequence
  sequence s_diag_event;
    ((ev.short_gnd & irq_en.short_gnd) | (ev.wire_break & irq_en.wire_break))
      != 8'h00 && !wr_ien;
  endsequence
  sequence s_diag_raised;
    ((status.short_gnd & irq_en.short_gnd) | (status.wire_break & irq_en.wire_break))
      != 8'h00 ##1 irq;
  endsequence

  // assertions
  a_group_fault_or: assert property (@(posedge clk) disable iff (!resetn)
    group_fault_indicator == (channel_fault != 8'h00))
    else $error("group fault not the or of channel faults");
  a_fault_needs_en: assert property (@(posedge clk) disable iff (!resetn)
    (channel_fault & ~(diag_en.short_en | diag_en.break_en)) == 8'h00)
    else $error("fault shown on disabled channel");
  a_edge_en_gated: assert property (@(posedge clk) disable iff (!resetn)
    !hw_irq_en |-> edge_en == '0)
    else $error("edge enable set without hardware enable");
  a_rise_needs_en: assert property (@(posedge clk) disable iff (!resetn)
    (ev.rise & ~edge_en.rise_en) == 8'h00)
    else $error("rise event on disabled channel");
  a_fall_needs_en: assert property (@(posedge clk) disable iff (!resetn)
    (ev.fall & ~edge_en.fall_en) == 8'h00)
    else $error("fall event on disabled channel");
  a_rise_sticky: assert property (@(posedge clk) disable iff (!resetn)
    ev.rise != 8'h00 |=> (status.rise & $past(ev.rise)) == $past(ev.rise))
    else $error("rise event not recorded");
  a_diag_gated: assert property (@(posedge clk) disable iff (!resetn)
    !diag_irq_en |-> (ev.short_gnd | ev.wire_break) == 8'h00)
    else $error("diagnostic event while module enable off");
  a_level_stable: assert property (@(posedge clk) disable iff (!resetn)
    $changed(level[0]) |-> $past(in_s[0]) == level[0])
    else $error("level changed without input agreeing");
  a_delay_min: assert property (@(posedge clk) disable iff (!resetn)
    (delay_sel == 2'h0 && $rose(level[0])) |-> $past(in_s[0], 8))
    else $error("level accepted too early");
  a_accept_not_early: assert property (@(posedge clk) disable iff (!resetn)
    $changed(level[0]) |-> $past(run0) + cw'(1) >= $past(limit))
    else $error("level accepted before the full delay");
  // a delay change in mid-count is legal, so only a steady limit is judged
  a_accept_on_time: assert property (@(posedge clk) disable iff (!resetn)
    run0 == limit && $stable(limit) |-> level[0] == $past(in_s[0]))
    else $error("level not accepted after the full delay");
  a_rise_irq_path: assert property (@(posedge clk) disable iff (!resetn)
    s_rise_event |=> s_rise_raised)
    else $error("enabled rising edge did not raise the interrupt");
  a_fall_irq_path: assert property (@(posedge clk) disable iff (!resetn)
    s_fall_event |=> s_fall_raised)
    else $error("enabled falling edge did not raise the interrupt");
  a_diag_irq_path: assert property (@(posedge clk) disable iff (!resetn)
    s_diag_event |=> s_diag_raised)
    else $error("enabled fault onset did not raise the interrupt");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (status & irq_en) == 32'h0000_0000 |=> !irq)
    else $error("interrupt without an enabled status bit");
  a_rise_level: assert property (@(posedge clk) disable iff (!resetn)
    ev.rise != 8'h00 |=> (level & $past(ev.rise)) == $past(ev.rise))
    else $error("rise event without the level going high");
  a_fall_level: assert property (@(posedge clk) disable iff (!resetn)
    ev.fall != 8'h00 |=> (level & $past(ev.fall)) == 8'h00)
    else $error("fall event without the level going low");
  a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
    !wr_clr |=> (status & $past(status)) == $past(status))
    else $error("status bit lost without a clear");
  a_clear_lands: assert property (@(posedge clk) disable iff (!resetn)
    wr_clr |=> (status & $past(wdata) & ~$past(ev)) == 32'h0000_0000)
    else $error("cleared status bit still set");
  a_fault_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (sh_s | br_s) == 8'h00 |-> !group_fault_indicator)
    else $error("group fault without any detected fault");
endmodule
`default_nettype wire

// ### inc/diag_input_pkg.sv
// constants and carriers for the eight-channel diagnostic input unit
// assumes a 200 MHz clock; times are converted to cycles here
package diag_input_pkg;
  localparam int unsigned clk_mhz      = 200;
  localparam int unsigned channels     = 8;
  // filter delay choices in microseconds
  localparam int unsigned delay0_us    = 500;
  localparam int unsigned delay1_us    = 3000;
  localparam int unsigned delay2_us    = 15000;
  localparam int unsigned delay3_us    = 20000;
  // a least time: cycles computed exactly, no rounding needed at 200 MHz
  localparam int unsigned delay0_cyc   = delay0_us * clk_mhz;
  localparam int unsigned delay1_cyc   = delay1_us * clk_mhz;
  localparam int unsigned delay2_cyc   = delay2_us * clk_mhz;
  localparam int unsigned delay3_cyc   = delay3_us * clk_mhz;
  localparam logic [1:0]  delay_sel_rst = 2'h1;
  // register offsets (byte addresses)
  localparam logic [7:0]  off_input    = 8'h00;
  localparam logic [7:0]  off_config   = 8'h04;
  localparam logic [7:0]  off_diag_en  = 8'h08;
  localparam logic [7:0]  off_edge_en  = 8'h0c;
  localparam logic [7:0]  off_fault    = 8'h10;
  localparam logic [7:0]  off_status   = 8'h14;
  localparam logic [7:0]  off_clear    = 8'h18;
  localparam logic [7:0]  off_irq_en   = 8'h1c;
  // config field positions
  localparam int unsigned cfg_delay_lsb = 0;
  localparam int unsigned cfg_diag_irq  = 2;
  localparam int unsigned cfg_hw_irq    = 3;
  // status layout: [7:0] rising, [15:8] falling, [23:16] short, [31:24] break
  typedef struct packed {
    logic [7:0] wire_break;
    logic [7:0] short_gnd;
    logic [7:0] fall;
    logic [7:0] rise;
  } event_s;
  typedef struct packed {
    logic [7:0] break_en;
    logic [7:0] short_en;
  } diag_en_s;
  typedef struct packed {
    logic [7:0] fall_en;
    logic [7:0] rise_en;
  } edge_en_s;
endpackage

// ### tb/field_sensors.sv
// field side: switches and sensors on the eight inputs and fault comparators
// assumes the bench sets contact levels; bounces only when the bench pulses them
`timescale 1ns/1ps
`default_nettype none
module field_sensors (
  input  wire logic       clk,
  input  wire logic [7:0] want_level,
  input  wire logic [7:0] want_short,
  input  wire logic [7:0] want_break,
  output logic      [7:0] field_in,
  output logic      [7:0] short_det,
  output logic      [7:0] break_det
);
  // contacts move one edge after the bench, on the same clk edge that the unit samples on
  always_ff @(posedge clk) begin
    field_in  <= want_level;
    short_det <= want_short;
    break_det <= want_break;
  end
endmodule
`default_nettype wire

// ### tb/test_diag_digital_input_unit.sv
// self-checking bench for the eight-channel diagnostic input unit
// assumes shortened filter counts; the field side comes from field_sensors
`timescale 1ns/1ps
`default_nettype none
module test_diag_digital_input_unit;
  localparam int unsigned dly [4] = '{10, 20, 40, 80};
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  want_level = 8'h00;
  logic [7:0]  want_short = 8'h00;
  logic [7:0]  want_break = 8'h00;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  field_in, short_det, break_det, level, channel_fault;
  logic [31:0] rdata, rv;
  logic        group_fault_indicator, irq;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #2.5 clk = ~clk;
  field_sensors u_field (.clk(clk), .want_level(want_level), .want_short(want_short),
    .want_break(want_break), .field_in(field_in), .short_det(short_det),
    .break_det(break_det));
  diag_digital_input_unit #(.delay0_cycles(10), .delay1_cycles(20), .delay2_cycles(40),
    .delay3_cycles(80)) u_dut (.clk(clk), .resetn(resetn), .field_in(field_in),
    .short_det(short_det), .break_det(break_det), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .level(level), .channel_fault(channel_fault),
    .group_fault_indicator(group_fault_indicator), .irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic t_reset();
    rd_reg(diag_input_pkg::off_config);
    check(rv, 32'h00000001);
    rd_reg(diag_input_pkg::off_diag_en);
    check(rv, 32'h0);
    rd_reg(diag_input_pkg::off_edge_en);
    check(rv, 32'h0);
    rd_reg(8'h40);
    check(rv, 32'h0);
    check(32'(irq), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_lock();
    wr_reg(diag_input_pkg::off_edge_en, 32'h0000ffff);
    rd_reg(diag_input_pkg::off_edge_en);
    check(rv, 32'h0);
    wr_reg(diag_input_pkg::off_config, 32'h9);
    wr_reg(diag_input_pkg::off_edge_en, 32'h00000402);
    rd_reg(diag_input_pkg::off_edge_en);
    check(rv, 32'h00000402);
    wr_reg(diag_input_pkg::off_config, 32'h1);
    rd_reg(diag_input_pkg::off_edge_en);
    check(rv, 32'h0);
    $display("test edge lock done");
  endtask
  // bound of four covers the field model edge and the two-flop sync
  task automatic settle(input int lo, input logic v);
    int n;
    n = 0;
    while (level[0] !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(32'(n >= lo && n <= lo + 4), 32'h1);
  endtask
  task automatic t_delay();
    wr_reg(diag_input_pkg::off_config, 32'h0);
    want_level[7] <= 1'b1;
    repeat (3) @(posedge clk);
    want_level[7] <= 1'b0;
    repeat (20) @(posedge clk);
    check(32'(level[7]), 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr_reg(diag_input_pkg::off_config, 32'(s));
      want_level[0] <= 1'b1;
      settle(dly[s], 1'b1);
      @(posedge clk);
      want_level[0] <= 1'b0;
      settle(dly[s], 1'b0);
    end
    $display("test delay done");
  endtask
  task automatic t_edges();
    wr_reg(diag_input_pkg::off_config, 32'h9);
    wr_reg(diag_input_pkg::off_edge_en, 32'h00000402);
    wr_reg(diag_input_pkg::off_irq_en, 32'h00000402);
    wr_reg(diag_input_pkg::off_clear, 32'hffffffff);
    want_level <= 8'h06;
    repeat (30) @(posedge clk);
    rd_reg(diag_input_pkg::off_status);
    check(rv, 32'h00000002);
    check(32'(irq), 32'h1);
    rd_reg(diag_input_pkg::off_input);
    check(rv, 32'h00000006);
    // field drives move on the rising edge only
    @(posedge clk);
    want_level <= 8'h00;
    repeat (30) @(posedge clk);
    rd_reg(diag_input_pkg::off_status);
    check(rv, 32'h00000402);
    wr_reg(diag_input_pkg::off_clear, 32'h00000002);
    rd_reg(diag_input_pkg::off_status);
    check(rv, 32'h00000400);
    wr_reg(diag_input_pkg::off_irq_en, 32'h0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    $display("test edges done");
  endtask
  task automatic t_diag();
    wr_reg(diag_input_pkg::off_clear, 32'hffffffff);
    wr_reg(diag_input_pkg::off_diag_en, 32'h00001008);
    wr_reg(diag_input_pkg::off_config, 32'h5);
    wr_reg(diag_input_pkg::off_irq_en, 32'hffff0000);
    want_short <= 8'h0c;
    want_break <= 8'h10;
    repeat (6) @(posedge clk);
    check(32'(channel_fault), 32'h18);
    check(32'(group_fault_indicator), 32'h1);
    rd_reg(diag_input_pkg::off_status);
    check(rv, 32'h10080000);
    check(32'(irq), 32'h1);
    rd_reg(diag_input_pkg::off_fault);
    check(rv, 32'h00001008);
    @(posedge clk);
    want_short <= 8'h00;
    want_break <= 8'h00;
    wr_reg(diag_input_pkg::off_config, 32'h1);
    wr_reg(diag_input_pkg::off_clear, 32'hffffffff);
    repeat (4) @(posedge clk);
    check(32'(group_fault_indicator), 32'h0);
    want_short <= 8'h08;
    repeat (6) @(posedge clk);
    check(32'(channel_fault), 32'h08);
    check(32'(irq), 32'h0);
    $display("test diag done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_lock();
    t_delay();
    t_edges();
    t_diag();
    end_sim();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
